// ===== hw/dfrs_pkg.sv
// constants for the ds3 far-end alarm receive status block
package dfrs_pkg;

    // =====================================================
    // apb register map
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned REG_IDX_W = 10;
    // printed offsets are word indexes; byte address is four times
    localparam logic [REG_IDX_W-1:0] RX_CODE_STATUS_IDX = 10'h01d;
    localparam logic [REG_IDX_W-1:0] INT_STATUS_IDX = 10'h020;
    localparam logic [REG_IDX_W-1:0] INT_MASK_IDX = 10'h021;

    // =====================================================
    // receive code status fields
    localparam int unsigned IDLE_BIT = 7;
    localparam int unsigned NEW_BIT = 6;
    localparam int unsigned FIELD_W = 6;
    localparam int unsigned STATUS_W = 8;
    localparam logic IDLE_RST = 1'b1;
    localparam logic NEW_RST = 1'b0;
    localparam logic [FIELD_W-1:0] FIELD_RST = 6'h00;

    // =====================================================
    // interrupt status and mask layout
    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_NEW_BIT = 0;
    localparam int unsigned INT_IDLE_ON_BIT = 1;
    localparam int unsigned INT_IDLE_OFF_BIT = 2;
    localparam logic [INT_W-1:0] INT_STATUS_RST = 3'h0;
    localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

    // =====================================================
    // code word framing
    localparam int unsigned WORD_W = 16;
    localparam logic [7:0] WORD_ONES = 8'hff;
    localparam int unsigned RUN_W = 5;
    localparam logic [RUN_W-1:0] IDLE_RUN_LEN = 5'h10;
    localparam int unsigned REPEAT_W = 3;
    localparam logic [REPEAT_W-1:0] LEGACY_REPEAT = 3'h5;

endpackage

// ===== hw/dfrs_rx_status.sv
// receive code word status register with apb access and interrupt
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dfrs_rx_status
    import dfrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic c3_clk,
    input wire logic c3_data,
    input wire logic legacy_sel,
    output logic irq
);

    // =====================================================
    // shared decode
    function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                     input logic [REG_IDX_W-1:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // sticky bits: a set in the clearing cycle wins
    function automatic logic [INT_W-1:0] sticky_next(input logic [INT_W-1:0] held,
                                                     input logic [INT_W-1:0] clr,
                                                     input logic [INT_W-1:0] set_bits);
        sticky_next = (held & ~clr) | set_bits;
    endfunction

    // =====================================================
    // pin synchronisers
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] legacy_sync;
    logic clk_prev;
    logic bit_valid;

    // bit clock and data share one delay, so each bit meets its own edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync <= 2'b00;
        end else begin
            clk_sync <= {clk_sync[0], c3_clk};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_sync <= 2'b00;
        end else begin
            data_sync <= {data_sync[0], c3_data};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            legacy_sync <= 2'b00;
        end else begin
            legacy_sync <= {legacy_sync[0], legacy_sel};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_sync[1];
        end
    end

    // rising edge of the line bit clock carries one c3 bit
    assign bit_valid = clk_sync[1] && !clk_prev;

    // =====================================================
    // word framing
    logic word_found;
    logic [FIELD_W-1:0] word_field;
    logic idle_run_seen;

    dfrs_word_framer u_framer (
        .pclk(pclk),
        .presetn(presetn),
        .bit_valid(bit_valid),
        .bit_value(data_sync[1]),
        .word_found(word_found),
        .word_field(word_field),
        .idle_run_seen(idle_run_seen)
    );

    // =====================================================
    // message validation
    logic [FIELD_W-1:0] last_field;
    logic have_last;
    logic [REPEAT_W-1:0] repeat_cnt;
    logic [REPEAT_W-1:0] next_repeat_cnt;
    logic same_word;
    logic accept;

    assign same_word = have_last && (word_field == last_field);

    always_comb begin
        if (!same_word) begin
            next_repeat_cnt = 3'h1;
        end else if (repeat_cnt == LEGACY_REPEAT) begin
            next_repeat_cnt = repeat_cnt;
        end else begin
            next_repeat_cnt = repeat_cnt + 3'h1;
        end
    end

    always_comb begin
        if (!word_found) begin
            accept = 1'b0;
        end else if (legacy_sync[1]) begin
            // saturated count lets every further identical word re-set new
            accept = (next_repeat_cnt == LEGACY_REPEAT);
        end else begin
            accept = !same_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_field <= FIELD_RST;
            have_last <= 1'b0;
        end else if (word_found) begin
            last_field <= word_field;
            have_last <= 1'b1;
        end else if (idle_run_seen) begin
            // an idle channel forgets the previous word
            have_last <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_cnt <= '0;
        end else if (word_found) begin
            repeat_cnt <= next_repeat_cnt;
        end else if (idle_run_seen) begin
            repeat_cnt <= '0;
        end
    end

    // =====================================================
    // apb phase decode
    logic setup_rd;
    logic access_wr;
    logic hit_code;
    logic hit_int_status;
    logic hit_int_mask;
    logic read_clear;

    assign setup_rd = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign hit_code = reg_hit(paddr, RX_CODE_STATUS_IDX);
    assign hit_int_status = reg_hit(paddr, INT_STATUS_IDX);
    assign hit_int_mask = reg_hit(paddr, INT_MASK_IDX);
    // read side effect is taken at the setup edge, with the data capture
    assign read_clear = setup_rd && hit_code;

    // =====================================================
    // receive code status register
    logic idle_flag;
    logic new_flag;
    logic [FIELD_W-1:0] rx_field;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_flag <= IDLE_RST;
        end else if (word_found) begin
            idle_flag <= 1'b0;
        end else if (idle_run_seen) begin
            idle_flag <= 1'b1;
        end
        // reads never reach this flag
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_flag <= NEW_RST;
        end else if (accept) begin
            new_flag <= 1'b1;
        end else if (read_clear) begin
            new_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_field <= FIELD_RST;
        end else if (accept) begin
            rx_field <= word_field;
        end
    end

    // =====================================================
    // interrupt status, mask and output
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_event;
    logic [INT_W-1:0] int_w1c;
    logic [INT_W-1:0] next_int_status;

    always_comb begin
        int_event = '0;
        int_event[INT_NEW_BIT] = accept;
        int_event[INT_IDLE_ON_BIT] = idle_run_seen && !idle_flag && !word_found;
        int_event[INT_IDLE_OFF_BIT] = word_found && idle_flag;
    end

    assign int_w1c = (access_wr && hit_int_status) ? pwdata[INT_W-1:0] : '0;
    assign next_int_status = sticky_next(int_status, int_w1c, int_event);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= INT_STATUS_RST;
        end else begin
            // an event in the clearing cycle is kept
            int_status <= next_int_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= INT_MASK_RST;
        end else if (access_wr && hit_int_mask) begin
            int_mask <= pwdata[INT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            // follows the next status value, so it settles with the status bits
            irq <= |(next_int_status & int_mask);
        end
    end

    // =====================================================
    // apb read data and error, captured in the setup cycle
    logic [APB_DATA_W-1:0] next_prdata;
    logic mapped;

    assign mapped = hit_code || hit_int_status || hit_int_mask;

    always_comb begin
        next_prdata = '0;
        if (hit_code) begin
            // idle/new pairs: 1/0 idle and quiet, x/1 new word
            next_prdata[IDLE_BIT] = idle_flag;
            next_prdata[NEW_BIT] = new_flag;
            next_prdata[FIELD_W-1:0] = rx_field;
        end else if (hit_int_status) begin
            next_prdata[INT_W-1:0] = int_status;
        end else if (hit_int_mask) begin
            next_prdata[INT_W-1:0] = int_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_rd) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !mapped;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // every access completes in its first access cycle
    assign pready = 1'b1;

endmodule

`default_nettype wire

// ===== hw/dfrs_word_framer.sv
// finds 16-bit code words and all-ones runs in the c3 bit stream
`timescale 1ns/1ps
`default_nettype none

module dfrs_word_framer
    import dfrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_valid,
    input wire logic bit_value,
    output logic word_found,
    output logic [FIELD_W-1:0] word_field,
    output logic idle_run_seen
);

    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] next_shift;
    logic [RUN_W-1:0] ones_run;
    logic match;

    // =====================================================
    // oldest bit sits in the top position
    assign next_shift = {shift[WORD_W-2:0], bit_value};
    assign match = (next_shift[15] == 1'b0) && (next_shift[8] == 1'b0)
        && (next_shift[7:0] == WORD_ONES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift <= {WORD_W{1'b1}};
        end else if (bit_valid) begin
            shift <= next_shift;
        end
    end

    // =====================================================
    // first received variable bit lands in field bit 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_found <= 1'b0;
            word_field <= FIELD_RST;
        end else begin
            word_found <= bit_valid && match;
            if (bit_valid && match) begin
                word_field <= {next_shift[9], next_shift[10], next_shift[11],
                    next_shift[12], next_shift[13], next_shift[14]};
            end
        end
    end

    // =====================================================
    // idle channel: a full word time of ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones_run <= '0;
            idle_run_seen <= 1'b0;
        end else begin
            idle_run_seen <= 1'b0;
            if (bit_valid) begin
                if (!bit_value) begin
                    ones_run <= '0;
                end else if (ones_run != IDLE_RUN_LEN) begin
                    ones_run <= ones_run + 5'h01;
                    idle_run_seen <= (ones_run == IDLE_RUN_LEN - 5'h01);
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/dfrs_line_model.sv
// remote terminal model sending c3 bits
`timescale 1ns/1ps
`default_nettype none

module dfrs_line_model (
    input wire logic pclk,
    output logic c3_clk,
    output logic c3_data
);
    initial begin
        c3_clk = 1'b0;
        c3_data = 1'b1;
    end
    // n bits lsb first; clock stands still after the frame
    task automatic send(input logic [15:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            c3_data <= w[i];
            repeat (4) @(posedge pclk);
            c3_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            c3_clk <= 1'b0;
        end
        @(posedge pclk);
        c3_data <= ~c3_data;
    endtask
    task automatic word(input logic [5:0] f);
        send({8'hff, 1'b0, f, 1'b0}, 16);
    endtask
endmodule

`default_nettype wire

// ===== tb/dfrs_monitor.sv
// assertion checker for the receive status block
`timescale 1ns/1ps
`default_nettype none

module dfrs_monitor
    import dfrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic c3_clk,
    input wire logic c3_data,
    input wire logic legacy_sel,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] low_cnt;
    logic quiet_run;
    logic quiet_ok;
    logic [7:0] last_stat;
    wire logic st_set = psel && !penable && !pwrite && paddr == 12'h074;
    wire logic acc = psel && penable;
    wire logic bad = paddr != 12'h074 && paddr != 12'h080 && paddr != 12'h084;
    // =========
    // line quiet tracking between two status reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 4'h0;
        end else if (c3_clk) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != 4'hf) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_run <= 1'b0;
            quiet_ok <= 1'b0;
        end else if (st_set) begin
            quiet_ok <= quiet_run && !c3_clk;
            quiet_run <= low_cnt > 4'hb && !c3_clk;
        end else if (c3_clk) begin
            quiet_run <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_stat <= 8'h80;
        end else if (acc && !pwrite && paddr == 12'h074) begin
            last_stat <= prdata[7:0];
        end
    end
    sequence s_rd_st;
        st_set ##1 acc;
    endsequence
    sequence s_quiet_rd;
        s_rd_st ##0 quiet_ok;
    endsequence
    a_read_keeps_idle: assert property (s_quiet_rd |-> prdata[7] == last_stat[7])
        else $error("idle flag changed by read");
    a_read_clears_new: assert property (s_quiet_rd |-> !prdata[6])
        else $error("new flag not cleared by read");
    a_field_kept: assert property (s_quiet_rd |-> prdata[5:0] == last_stat[5:0])
        else $error("field changed without line activity");
    a_status_upper_zero: assert property (s_rd_st |-> prdata[31:8] == 24'h0)
        else $error("status upper bits set");
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_on_unmapped: assert property (acc |-> pslverr == bad)
        else $error("pslverr wrong for address");
    a_err_reads_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_int_upper_zero: assert property (acc && !pwrite && !bad && paddr != 12'h074
        |-> prdata[31:3] == 29'h0)
        else $error("interrupt register upper bits set");
    a_prdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without read");
    a_irq_clear_quiet: assert property (acc && pwrite && paddr == 12'h080
        && pwdata[2:0] == 3'h7 && low_cnt > 4'hb |=> !irq)
        else $error("irq high after clearing every status bit");
endmodule

bind dfrs_rx_status dfrs_monitor dfrs_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .c3_clk(c3_clk), .c3_data(c3_data), .legacy_sel(legacy_sel), .irq(irq)
);

`default_nettype wire

// ===== tb/dfrs_rx_status_bench.sv
// bench for the receive status block
`timescale 1ns/1ps
`default_nettype none

module dfrs_rx_status_bench
    import dfrs_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic legacy_sel = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [APB_DATA_W-1:0] pwdata = '0;
    logic [APB_DATA_W-1:0] prdata;
    logic [APB_DATA_W-1:0] rd;
    logic pready, pslverr, irq, c3_clk, c3_data, err;
    int errors = 0;
    int n_checks = 0;
    always #5 pclk = ~pclk;
    dfrs_rx_status dfrs_rx_status_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .c3_clk(c3_clk), .c3_data(c3_data), .legacy_sel(legacy_sel), .irq(irq));
    dfrs_line_model dfrs_line_model_inst (.pclk(pclk), .c3_clk(c3_clk), .c3_data(c3_data));
    // =========
    // tasks
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic wd(input logic [5:0] f, input int k);
        repeat (k) dfrs_line_model_inst.word(f);
        repeat (12) @(posedge pclk);
    endtask
    task automatic idle();
        dfrs_line_model_inst.send(16'hffff, 16);
        repeat (12) @(posedge pclk);
    endtask
    // =========
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc("status", 12'h074, 32'h80, '1);
        rdc("int status", 12'h080, 32'h0, '1);
        rdc("int mask", 12'h084, 32'h0, '1);
        rdc("unmapped", 12'h078, 32'h0, '1);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, 12'h074, 32'hff);
        rdc("status ro", 12'h074, 32'h80, '1);
        apb(1'b1, 12'h084, 32'h7);
        wd(6'h2d, 1);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("status", 12'h074, 32'h6d, '1);
        rdc("int status", 12'h080, 32'h5, '1);
        apb(1'b1, 12'h080, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rdc("status", 12'h074, 32'h2d, '1);
        wd(6'h2d, 1);
        rdc("status", 12'h074, 32'h2d, '1);
        wd(6'h13, 1);
        wd(6'h0a, 1);
        rdc("status", 12'h074, 32'h4a, '1);
        apb(1'b1, 12'h084, 32'h4);
        idle();
        rdc("status", 12'h074, 32'h80, 32'hc0);
        rdc("int status", 12'h080, 32'h3, '1);
        chk("irq", 32'h0, {31'h0, irq});
        wd(6'h21, 1);
        chk("irq", 32'h1, {31'h0, irq});
        idle();
        rdc("status", 12'h074, 32'he1, '1);
        legacy_sel <= 1'b1;
        wd(6'h1e, 4);
        rdc("status", 12'h074, 32'h21, '1);
        wd(6'h1e, 1);
        rdc("status", 12'h074, 32'h5e, '1);
        wd(6'h1e, 1);
        rdc("status", 12'h074, 32'h5e, '1);
        legacy_sel <= 1'b0;
        wd(6'h1e, 1);
        rdc("status", 12'h074, 32'h1e, '1);
        conclude();
    end
endmodule

`default_nettype wire
